// *** timer_clock_pkg.sv ***
package timer_clock_pkg;

    localparam int NUM_CH = 6;
    localparam int NUM_EXT = 4;
    localparam int NUM_GR_PINS = 16;
    localparam int NUM_TAPS = 5;
    localparam int PRESCALE_WIDTH = 10;

    // register byte offsets
    localparam logic [11:0] CTRL_BASE = 12'h000;
    localparam logic [11:0] START_OFS = 12'h018;
    localparam logic [11:0] SYNC_OFS = 12'h01C;
    localparam logic [11:0] PHASE_OFS = 12'h020;
    localparam logic [11:0] PIN_DRV_OFS = 12'h024;
    localparam logic [11:0] PIN_VAL_OFS = 12'h028;
    localparam logic [11:0] PIN_IN_OFS = 12'h02C;
    localparam logic [11:0] CNT_BASE = 12'h040;

    // control register fields and reset
    localparam int CLR_MSB = 7;
    localparam int CLR_LSB = 5;
    localparam int EDGE_MSB = 4;
    localparam int EDGE_LSB = 3;
    localparam int SRC_MSB = 2;
    localparam int SRC_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] CH_RESET = 6'h00;
    localparam logic [15:0] PIN_RESET = 16'h0000;

    // clear source codes
    localparam logic [2:0] CLR_BY_A = 3'h1;
    localparam logic [2:0] CLR_BY_B = 3'h2;
    localparam logic [2:0] CLR_BY_C = 3'h5;
    localparam logic [2:0] CLR_BY_D = 3'h6;
    localparam logic [1:0] CLR_SYNC_LOW = 2'h3;

    // edge codes
    localparam logic [1:0] EDGE_FIRST = 2'h0;

    // channel capabilities
    localparam logic [5:0] PHASE_CAPABLE = 6'h36;
    localparam logic [5:0] FOUR_GR = 6'h09;
    localparam int GR_PIN_BASE [NUM_CH] = '{0, 4, 6, 8, 12, 14};
    localparam int PHASE_A_PIN [NUM_CH] = '{0, 0, 2, 0, 2, 0};
    localparam int CASCADE_FROM [NUM_CH] = '{0, 2, 0, 0, 5, 0};

    typedef enum logic [3:0] {
        SRC_DIV1, SRC_DIV4, SRC_DIV16, SRC_DIV64, SRC_DIV256, SRC_DIV1024,
        SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D, SRC_CASCADE
    } clock_src_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

    function automatic clock_src_type select_source(input int ch, input logic [2:0] code);
        clock_src_type s;
        case (code)
            3'h0: s = SRC_DIV1;
            3'h1: s = SRC_DIV4;
            3'h2: s = SRC_DIV16;
            3'h3: s = SRC_DIV64;
            3'h4: s = SRC_PIN_A;
            3'h5: s = SRC_PIN_B;
            3'h6: s = (ch % 3 == 1) ? SRC_DIV256 : SRC_PIN_C;
            3'h7: s = (ch % 3 == 0) ? SRC_PIN_D : ((ch % 3 == 1) ? SRC_CASCADE : SRC_DIV1024);
            default: s = SRC_DIV1;
        endcase
        return s;
    endfunction : select_source

endpackage : timer_clock_pkg

// *** pin_synchronizer.sv ***
`timescale 1ns/1ps
module pin_synchronizer import timer_clock_pkg::*; #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } sync_state_type;

    sync_state_type q;
    sync_state_type next_q;
    logic [WIDTH-1:0] change;

    if (WIDTH < 1) begin : g_check
        $error("pin_synchronizer needs at least one pin");
    end

    always_comb begin
        change = ~(q.s2 ^ q.s3) & (q.s3 ^ q.level);
        next_q = q;
        next_q.s1 = pin;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.level = q.level ^ change;
        next_q.rise = change & q.s3;
        next_q.fall = change & ~q.s3;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level = q.level;
    assign rise = q.rise;
    assign fall = q.fall;
endmodule : pin_synchronizer

// *** prescaler_taps.sv ***
`timescale 1ns/1ps
module prescaler_taps import timer_clock_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    output logic [NUM_TAPS-1:0] tap_rise,
    output logic [NUM_TAPS-1:0] tap_fall
);
    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] cnt;
        logic [NUM_TAPS-1:0] tap_q;
        logic [NUM_TAPS-1:0] rise;
        logic [NUM_TAPS-1:0] fall;
    } pre_state_type;

    pre_state_type q;
    pre_state_type next_q;
    logic [NUM_TAPS-1:0] taps;

    // taps for /4, /16, /64, /256, /1024 square waves
    for (genvar t = 0; t < NUM_TAPS; t++) begin : g_tap
        assign taps[t] = q.cnt[2 * t + 1];
    end

    always_comb begin
        next_q = q;
        next_q.cnt = q.cnt + 1'b1;
        next_q.tap_q = taps;
        next_q.rise = taps & ~q.tap_q;
        next_q.fall = ~taps & q.tap_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tap_rise = q.rise;
    assign tap_fall = q.fall;
endmodule : prescaler_taps

// *** timer_count_clock_select.sv ***
// What this block does
// - six 8-bit read/write control registers, all bits reset to zero
// - bits 7..5 pick the event that clears the channel counter
// - bits 4..3 pick the count clock edge
// - both-edge setting counts rising and falling edges, doubling the rate
// - phase counting mode overrides the edge setting on capable channels
// - internal edge choice applies only to divide-by-four or slower clocks
// - edge choice ignored for undivided clock or another channel's overflow
// - bits 2..0 pick each channel's count clock independently
// - external inputs A and B feed all channels and phase on 1 and 5
// - external input C feeds channels 0, 2, 3 and 5, D only 0 and 3; C and D phase on 2 and 4
// - four shared input-only external clock pins A to D
// - each general register owns one two-way pin
// - channels 0 and 3 have four general registers, others two
// - one common start register and one common sync register
// - clear codes: 0/4 none, 1 A, 2 B, 5 C, 6 D, 3/7 synchronous
// - bit 7 reads zero and ignores writes on two-register channels
// - edge 00 internal falling/external rising, 01 reverse, 1x both
// - channel 0 codes 0,1 pick /1,/4; codes 4..7 pick pins A..D
`timescale 1ns/1ps
module timer_count_clock_select import timer_clock_pkg::*; #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_type apb_req,
    output apb_rsp_type apb_rsp,
    input wire logic [NUM_EXT-1:0] ext_clock_in,
    input wire logic [NUM_CH-1:0][3:0] match_event,
    input wire logic [NUM_GR_PINS-1:0] gr_pin_in,
    output logic [NUM_GR_PINS-1:0] gr_pin_out,
    output logic [NUM_GR_PINS-1:0] gr_pin_oe_n,
    output logic [NUM_CH-1:0] count_pulse,
    output logic [NUM_CH-1:0] counter_clear
);
    typedef logic [COUNT_WIDTH-1:0] count_type;

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] ctrl;
        logic [NUM_CH-1:0] start;
        logic [NUM_CH-1:0] sync_en;
        logic [NUM_CH-1:0] phase_en;
        logic [NUM_GR_PINS-1:0] pin_drv;
        logic [NUM_GR_PINS-1:0] pin_val;
        count_type [NUM_CH-1:0] cnt;
        logic [NUM_CH-1:0] ovf;
        logic [NUM_CH-1:0] pulse;
        logic [NUM_CH-1:0] clr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [NUM_GR_PINS-1:0] pin_out;
        logic [NUM_GR_PINS-1:0] pin_oe_n;
    } state_type;

    state_type q;
    state_type next_q;

    logic [NUM_EXT-1:0] ext_level;
    logic [NUM_EXT-1:0] ext_rise;
    logic [NUM_EXT-1:0] ext_fall;
    logic [NUM_GR_PINS-1:0] gr_level;
    logic [NUM_TAPS-1:0] pre_rise;
    logic [NUM_TAPS-1:0] pre_fall;
    logic [NUM_CH-1:0] step_up;
    logic [NUM_CH-1:0] step_dn;
    logic [NUM_CH-1:0] own_clr;
    logic [NUM_CH-1:0] sync_sel;
    clock_src_type csrc [NUM_CH];

    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd_data;
    logic [2:0] idx;

    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_check
        $error("COUNT_WIDTH must lie between 2 and 32");
    end

    // external clock pins, three-stage synchronised
    pin_synchronizer #(.WIDTH(NUM_EXT)) u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_clock_in),
        .level(ext_level),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // general register pin inputs
    pin_synchronizer #(.WIDTH(NUM_GR_PINS)) u_gr_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(gr_pin_in),
        .level(gr_level),
        .rise(),
        .fall()
    );

    prescaler_taps u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .tap_rise(pre_rise),
        .tap_fall(pre_fall)
    );

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic ext_src;
        logic e_rise;
        logic e_fall;
        logic tick;
        logic phase_on;
        logic a_r;
        logic a_f;
        logic b_r;
        logic b_f;
        logic a_l;
        logic b_l;
        logic [1:0] edge_sel;
        logic [2:0] clr_sel;

        always_comb begin
            edge_sel = q.ctrl[ch][EDGE_MSB:EDGE_LSB];
            clr_sel = q.ctrl[ch][CLR_MSB:CLR_LSB];
            csrc[ch] = select_source(ch, q.ctrl[ch][SRC_MSB:SRC_LSB]);
            ext_src = 1'b0;
            e_rise = 1'b0;
            e_fall = 1'b0;
            tick = 1'b0;
            case (csrc[ch])
                SRC_DIV4: begin
                    e_rise = pre_rise[0];
                    e_fall = pre_fall[0];
                end
                SRC_DIV16: begin
                    e_rise = pre_rise[1];
                    e_fall = pre_fall[1];
                end
                SRC_DIV64: begin
                    e_rise = pre_rise[2];
                    e_fall = pre_fall[2];
                end
                SRC_DIV256: begin
                    e_rise = pre_rise[3];
                    e_fall = pre_fall[3];
                end
                SRC_DIV1024: begin
                    e_rise = pre_rise[4];
                    e_fall = pre_fall[4];
                end
                SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D: begin
                    ext_src = 1'b1;
                    e_rise = ext_rise[int'(csrc[ch]) - int'(SRC_PIN_A)];
                    e_fall = ext_fall[int'(csrc[ch]) - int'(SRC_PIN_A)];
                end
                default: begin
                end
            endcase
            // edge field decode for divided and pin clocks
            if (edge_sel[1]) begin
                tick = e_rise | e_fall;
            end else if (edge_sel == EDGE_FIRST) begin
                tick = ext_src ? e_rise : e_fall;
            end else begin
                tick = ext_src ? e_fall : e_rise;
            end
            // undivided clock and cascade ignore the edge field
            if (csrc[ch] == SRC_DIV1) begin
                tick = 1'b1;
            end else if (csrc[ch] == SRC_CASCADE) begin
                tick = q.ovf[CASCADE_FROM[ch]];
            end
            // quadrature decode from the paired pins
            a_r = ext_rise[PHASE_A_PIN[ch]];
            a_f = ext_fall[PHASE_A_PIN[ch]];
            b_r = ext_rise[PHASE_A_PIN[ch] + 1];
            b_f = ext_fall[PHASE_A_PIN[ch] + 1];
            a_l = ext_level[PHASE_A_PIN[ch]];
            b_l = ext_level[PHASE_A_PIN[ch] + 1];
            phase_on = PHASE_CAPABLE[ch] & q.phase_en[ch];
            if (phase_on) begin
                step_up[ch] = (a_r & ~b_l) | (a_f & b_l) | (b_r & a_l) | (b_f & ~a_l);
                step_dn[ch] = (a_r & b_l) | (a_f & ~b_l) | (b_r & ~a_l) | (b_f & a_l);
            end else begin
                step_up[ch] = tick;
                step_dn[ch] = 1'b0;
            end
            // clear source decode
            case (clr_sel)
                CLR_BY_A: own_clr[ch] = match_event[ch][0];
                CLR_BY_B: own_clr[ch] = match_event[ch][1];
                CLR_BY_C: own_clr[ch] = match_event[ch][2];
                CLR_BY_D: own_clr[ch] = match_event[ch][3];
                default: own_clr[ch] = 1'b0;
            endcase
            sync_sel[ch] = (clr_sel[1:0] == CLR_SYNC_LOW);
        end
    end

    // register decode
    always_comb begin
        idx = apb_req.paddr[4:2];
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (apb_req.paddr[11:5] == CTRL_BASE[11:5] && idx < 3'(NUM_CH)) begin
            rd_data = {24'h00_0000, q.ctrl[idx]};
        end else if (apb_req.paddr[11:5] == CNT_BASE[11:5] && idx < 3'(NUM_CH)) begin
            rd_data = 32'(q.cnt[idx]);
        end else begin
            case (apb_req.paddr)
                START_OFS: rd_data = {26'h000_0000, q.start};
                SYNC_OFS: rd_data = {26'h000_0000, q.sync_en};
                PHASE_OFS: rd_data = {26'h000_0000, q.phase_en};
                PIN_DRV_OFS: rd_data = {16'h0000, q.pin_drv};
                PIN_VAL_OFS: rd_data = {16'h0000, q.pin_val};
                PIN_IN_OFS: rd_data = {16'h0000, gr_level};
                default: hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        setup = apb_req.psel & ~apb_req.penable;
        access = apb_req.psel & apb_req.penable & q.pready;
        next_q = q;
        // counters, clears and synchronous clearing
        for (int ch = 0; ch < NUM_CH; ch++) begin
            next_q.clr[ch] = q.start[ch] & (own_clr[ch] | (sync_sel[ch] & q.sync_en[ch]
                & |(own_clr & q.sync_en & q.start & ~(6'h01 << ch))));
            next_q.pulse[ch] = 1'b0;
            next_q.ovf[ch] = 1'b0;
            if (next_q.clr[ch]) begin
                next_q.cnt[ch] = '0;
            end else if (q.start[ch] & step_up[ch]) begin
                next_q.cnt[ch] = q.cnt[ch] + 1'b1;
                next_q.pulse[ch] = 1'b1;
                next_q.ovf[ch] = &q.cnt[ch];
            end else if (q.start[ch] & step_dn[ch]) begin
                next_q.cnt[ch] = q.cnt[ch] - 1'b1;
                next_q.pulse[ch] = 1'b1;
                next_q.ovf[ch] = ~|q.cnt[ch];
            end
        end
        // bus answer, zero wait states
        next_q.pready = setup;
        next_q.pslverr = setup & ~hit;
        next_q.prdata = setup ? rd_data : 32'h0000_0000;
        if (access & apb_req.pwrite & hit) begin
            if (apb_req.paddr[11:5] == CTRL_BASE[11:5] && idx < 3'(NUM_CH)) begin
                next_q.ctrl[idx] = apb_req.pwdata[7:0];
                if (!FOUR_GR[idx]) begin
                    next_q.ctrl[idx][CLR_MSB] = 1'b0;
                end
            end else begin
                case (apb_req.paddr)
                    START_OFS: next_q.start = apb_req.pwdata[5:0];
                    SYNC_OFS: next_q.sync_en = apb_req.pwdata[5:0];
                    PHASE_OFS: next_q.phase_en = apb_req.pwdata[5:0] & PHASE_CAPABLE;
                    PIN_DRV_OFS: next_q.pin_drv = apb_req.pwdata[15:0];
                    PIN_VAL_OFS: next_q.pin_val = apb_req.pwdata[15:0];
                    default: begin
                    end
                endcase
            end
        end
        next_q.pin_out = q.pin_val;
        next_q.pin_oe_n = ~q.pin_drv;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.pin_oe_n <= ~PIN_RESET;
            q.ctrl <= {NUM_CH{CTRL_RESET}};
        end else begin
            q <= next_q;
        end
    end

    assign apb_rsp = '{prdata: q.prdata, pready: q.pready, pslverr: q.pslverr};
    assign gr_pin_out = q.pin_out;
    assign gr_pin_oe_n = q.pin_oe_n;
    assign count_pulse = q.pulse;
    assign counter_clear = q.clr;

    property p_reserved_bit;
        @(posedge pclk) disable iff (!presetn)
        !q.ctrl[1][7] && !q.ctrl[2][7] && !q.ctrl[4][7] && !q.ctrl[5][7];
    endproperty
    a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit set");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        access && apb_req.pwrite && apb_req.paddr == CTRL_BASE
        |=> q.ctrl[0] == $past(apb_req.pwdata[7:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_div1;
        @(posedge pclk) disable iff (!presetn)
        q.start[0] && q.ctrl[0][7:0] == 8'h18 |=> count_pulse[0];
    endproperty
    a_div1: assert property (p_div1) else $error("undivided clock missed");

    property p_clear_a;
        @(posedge pclk) disable iff (!presetn)
        q.start[0] && q.ctrl[0][7:5] == CLR_BY_A && match_event[0][0]
        |=> counter_clear[0] && q.cnt[0] == '0;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("clear on A missed");

    property p_both_edges;
        @(posedge pclk) disable iff (!presetn)
        q.start[0] && q.ctrl[0] == 8'h11 && (pre_rise[0] || pre_fall[0]) |=> count_pulse[0];
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("both-edge count missed");

    property p_fall_only;
        @(posedge pclk) disable iff (!presetn)
        q.start[0] && q.ctrl[0] == 8'h01 && pre_rise[0] |=> !count_pulse[0];
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("counted wrong edge");

    property p_phase_priority;
        @(posedge pclk) disable iff (!presetn)
        q.phase_en[1] && ext_rise == '0 && ext_fall == '0 |=> !count_pulse[1];
    endproperty
    a_phase_priority: assert property (p_phase_priority) else $error("phase mode counted");

    property p_ext_pin_a;
        @(posedge pclk) disable iff (!presetn)
        q.start[0] && q.ctrl[0] == 8'h04 && ext_rise[0] |=> count_pulse[0] ##1 !count_pulse[0];
    endproperty
    a_ext_pin_a: assert property (p_ext_pin_a) else $error("pin A edge missed");

    property p_sync_clear;
        @(posedge pclk) disable iff (!presetn)
        &q.start[1:0] && &q.sync_en[1:0] && q.ctrl[1][6:5] == CLR_SYNC_LOW && own_clr[0]
        |=> counter_clear[1] && counter_clear[0];
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

    property p_pin_enable;
        @(posedge pclk) disable iff (!presetn)
        ##1 gr_pin_oe_n == ~$past(q.pin_drv);
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable mismatch");

endmodule : timer_count_clock_select

// *** ext_clock_source.sv ***
`timescale 1ns/1ps
module ext_clock_source import timer_clock_pkg::*; (
    input wire logic pclk,
    output logic [NUM_EXT-1:0] ext_clock_in
);
    // input-only pins, idle low between bursts
    initial ext_clock_in = '0;

    // n pulses, 3 cycles high, 3 low
    task automatic pulses(input int pin, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            ext_clock_in[pin] <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_clock_in[pin] <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : pulses

    // quadrature on pin pair, a-phase leads b-phase
    task automatic quad(input int base, input int n);
        for (int i = 0; i < 4 * n; i++) begin
            @(posedge pclk);
            ext_clock_in[base + (i % 2)] <= (i % 4) < 2;
            repeat (3) @(posedge pclk);
        end
    endtask : quad
endmodule : ext_clock_source

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import timer_clock_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_type apb_req = '0;
    apb_rsp_type apb_rsp;
    logic [NUM_EXT-1:0] ext_clock_in;
    logic [NUM_CH-1:0][3:0] match_event = '0;
    logic [NUM_GR_PINS-1:0] gr_pin_in = '0;
    logic [NUM_GR_PINS-1:0] gr_pin_out;
    logic [NUM_GR_PINS-1:0] gr_pin_oe_n;
    logic [NUM_CH-1:0] count_pulse;
    logic [NUM_CH-1:0] counter_clear;
    int errors = 0;
    int num_checks = 0;
    int steps [NUM_CH];
    int clears [NUM_CH];
    logic [31:0] rd;
    logic err;
    always #50 pclk = ~pclk;
    timer_count_clock_select #(.COUNT_WIDTH(16)) dut (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_clock_in(ext_clock_in),
        .match_event(match_event), .gr_pin_in(gr_pin_in), .gr_pin_out(gr_pin_out),
        .gr_pin_oe_n(gr_pin_oe_n), .count_pulse(count_pulse), .counter_clear(counter_clear));
    ext_clock_source src (.pclk(pclk), .ext_clock_in(ext_clock_in));
    always @(posedge pclk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (count_pulse[i] === 1'b1) steps[i] <= steps[i] + 1;
            if (counter_clear[i] === 1'b1) clears[i] <= clears[i] + 1;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge pclk);
    endtask : apb

    task automatic setup(input int ch, input logic [7:0] ctrl);
        apb(1'b1, START_OFS, 32'h0000_0000);
        apb(1'b1, CTRL_BASE + 12'(4 * ch), {24'h0000_00, ctrl});
        apb(1'b1, START_OFS, 32'(1 << ch));
        repeat (8) @(posedge pclk);
    endtask : setup

    // clear count expected for clear code c and match event e
    function automatic logic [31:0] clear_expect(input int c, input int e);
        return 32'((c == int'(CLR_BY_A) && e == 0) || (c == int'(CLR_BY_B) && e == 1)
            || (c == int'(CLR_BY_C) && e == 2) || (c == int'(CLR_BY_D) && e == 3));
    endfunction : clear_expect

    int ch;
    int s;
    logic [31:0] v;
    logic [7:0] ctl [7] = '{8'h00, 8'h08, 8'h18, 8'h01, 8'h19, 8'h02, 8'h03};
    int per [7] = '{1, 1, 1, 4, 2, 16, 64};
    int ech [7] = '{0, 0, 0, 1, 2, 3, 5};
    logic [7:0] ectl [7] = '{8'h04, 8'h0C, 8'h14, 8'h15, 8'h06, 8'h0F, 8'h05};
    int epin [7] = '{0, 0, 0, 1, 2, 3, 1};
    int emul [7] = '{1, 1, 2, 2, 1, 1, 1};

    initial begin
        void'($urandom(35));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("oe_n reset", 32'h0000_FFFF, 32'(gr_pin_oe_n));
        for (int i = 0; i < NUM_CH; i++) begin
            apb(1'b0, CTRL_BASE + 12'(4 * i), 32'h0000_0000);
            check("ctrl reset", 32'h0000_0000, rd);
        end
        for (int k = 0; k < 18; k++) begin
            ch = k % NUM_CH;
            v = (k < NUM_CH) ? 32'h0000_00FF : $urandom;
            apb(1'b1, CTRL_BASE + 12'(4 * ch), v);
            apb(1'b0, CTRL_BASE + 12'(4 * ch), 32'h0000_0000);
            check("ctrl rw", {24'h0000_00, v[7] & FOUR_GR[ch], v[6:0]}, rd);
        end
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check("unmapped err", 32'h0000_0001, 32'(err));
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped data", {31'h0000_0000, 1'b1}, {rd[30:0], err});
        v = $urandom;
        apb(1'b1, PIN_DRV_OFS, {16'h0000, v[15:0]});
        apb(1'b1, PIN_VAL_OFS, {16'h0000, v[31:16]});
        @(posedge pclk);
        check("pin oe_n", {16'h0000, ~v[15:0]}, 32'(gr_pin_oe_n));
        check("pin out", {16'h0000, v[31:16]}, 32'(gr_pin_out));
        gr_pin_in <= v[23:8];
        repeat (6) @(posedge pclk);
        apb(1'b0, PIN_IN_OFS, 32'h0000_0000);
        check("pin in", {16'h0000, v[23:8]}, rd);
        for (int k = 0; k < 7; k++) begin
            ch = (k < 3) ? 0 : $urandom_range(NUM_CH - 1);
            setup(ch, ctl[k]);
            s = steps[ch];
            repeat (128) @(posedge pclk);
            check("internal rate", 32'(128 / per[k]), 32'(steps[ch] - s));
        end
        for (int k = 0; k < 7; k++) begin
            setup(ech[k], ectl[k]);
            s = steps[ech[k]];
            src.pulses(epin[k], 5);
            repeat (8) @(posedge pclk);
            check("external count", 32'(5 * emul[k]), 32'(steps[ech[k]] - s));
        end
        for (int c = 0; c < 8; c++) begin
            setup(0, 8'(c << 5));
            for (int e = 0; e < 4; e++) begin
                s = clears[0];
                match_event[0][e] <= 1'b1;
                @(posedge pclk);
                match_event <= '0;
                repeat (4) @(posedge pclk);
                check("clear source", clear_expect(c, e), 32'(clears[0] - s));
            end
        end
        apb(1'b1, PHASE_OFS, 32'h0000_0012);
        for (int k = 0; k < 2; k++) begin
            ch = k ? 4 : 1;
            setup(ch, 8'h18);
            s = steps[ch];
            src.quad(2 * k, 3);
            repeat (8) @(posedge pclk);
            check("phase count", 32'h0000_000C, 32'(steps[ch] - s));
        end
        apb(1'b1, START_OFS, 32'h0000_0000);
        apb(1'b0, CNT_BASE + 12'h004, 32'h0000_0000);
        check("counter 1", {16'h0000, 16'(steps[1])}, rd);
        apb(1'b1, CTRL_BASE, 32'h0000_0020);
        apb(1'b1, CTRL_BASE + 12'h004, 32'h0000_0060);
        apb(1'b1, SYNC_OFS, 32'h0000_0003);
        apb(1'b1, START_OFS, 32'h0000_0003);
        s = clears[1];
        match_event[0][0] <= 1'b1;
        @(posedge pclk);
        match_event <= '0;
        repeat (4) @(posedge pclk);
        check("sync clear", 32'h0000_0001, 32'(clears[1] - s));
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
endmodule : tb
